// File: inc/brd_pkg.sv
`default_nettype none
package brd_pkg;
	// ==========================================================
	// Timing base
	localparam int CLK_PERIOD_NS = 100;
	// Debounce window, least time so it rounds up
	localparam int DB_TIME_NS = 10000;
	localparam int DB_CYC = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DB_W = 8;
	// Master reset stretch after a watchdog or core reset request
	localparam int HOLD_TIME_NS = 20000;
	localparam int HOLD_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W = 8;
	// Watchdog period, longest time so it rounds down
	localparam longint WDT_TIME_MS = 1000;
	localparam longint WDT_CYC = WDT_TIME_MS * 64'd1000000 / CLK_PERIOD_NS;
	localparam int WDT_W = 32;
	// Fixed timer oscillator and operating system tick period
	localparam longint TIMER_OSC_HZ = 3686400;
	localparam longint TICK_TIME_US = 10000;
	localparam longint TICK_EDGES = TIMER_OSC_HZ * TICK_TIME_US / 64'd1000000;
	localparam int TICK_W = 16;
	// Reset values
	localparam logic MCLK_RST = 1'h1;
	localparam logic RST_ASSERTED_N = 1'h0;

	// ==========================================================
	// Sequencer states, gray along power-up, run, watchdog hold
	typedef enum logic [1:0]
	{
		ST_POR = 2'h0,
		ST_RUN = 2'h1,
		ST_HOLD = 2'h3
	} brd_seq_type;
endpackage : brd_pkg
`default_nettype wire

// File: inc/brd_dbnc_if.sv
`default_nettype none
interface brd_dbnc_if;
	logic raw_n;
	logic clean_n;
	modport src (output raw_n, input clean_n);
	modport flt (input raw_n, output clean_n);
endinterface : brd_dbnc_if
`default_nettype wire

// File: hw/brd_debounce.sv
`default_nettype none
module brd_debounce #(
	parameter int unsigned DB_CYC = brd_pkg::DB_CYC
) (
	input wire logic clk,
	input wire logic reset,
	brd_dbnc_if.flt f
);
	// ==========================================================
	// State
	typedef struct packed {
		logic clean_n;
		logic [brd_pkg::DB_W-1:0] cnt;
	} brd_db_state_type;

	brd_db_state_type q_r;
	brd_db_state_type q_nxt;

	// Output moves only once the input has held still a full window
	always_comb
	begin
		q_nxt = q_r;
		if (f.raw_n == q_r.clean_n)
			q_nxt.cnt = '0;
		else if (q_r.cnt == brd_pkg::DB_W'(DB_CYC - 1))
		begin
			q_nxt.clean_n = f.raw_n;
			q_nxt.cnt = '0;
		end
		else
			q_nxt.cnt = q_r.cnt + brd_pkg::DB_W'(1);
	end

	// Starts asserted so nothing leaves reset before the window
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			q_r.clean_n <= brd_pkg::RST_ASSERTED_N;
			q_r.cnt <= '0;
		end
		else
			q_r <= q_nxt;
	end

	assign f.clean_n = q_r.clean_n;

	// ==========================================================
	// Checks
	property p_db_settled;
		@(posedge clk) disable iff (reset)
		$changed(q_r.clean_n) |-> $past(f.raw_n) == q_r.clean_n
			&& $past(q_r.cnt) == brd_pkg::DB_W'(DB_CYC - 1);
	endproperty
	a_db_settled: assert property (p_db_settled)
		else $error("debounced reset changed without a full window");
endmodule : brd_debounce
`default_nettype wire

// File: hw/brd_reset_dist.sv
// Operation
// - Host bridge mode resets all local resources and drives PCI reset.
// - Host mode reset sources: power, button, debug, software, core, watchdog.
// - Debounced active-low power-on reset feeds flash and host master reset.
// - Expansion bus gets an inverted active-high copy of flash reset.
// - Button reset passes the same debounce path as power-on reset.
// - Debug port reset request is debounced by the same circuitry.
// - Watchdog resets only when enabled and allowed to expire; system wide in host mode.
// - Watchdog asserts master reset; host mode also resets flash, expansion.
// - PCI reset held from power-up until processor sets release bit.
// - Add-in mode: PCI reset resets core, flash, bus; processor via master.
// - Core logic can hold processor in reset during flash programming.
// - Add-in mode: asserted PCI reset input asserts processor master reset.
// - Blank programming keeps processor in reset until power-down.
// - Processor memory clock stalls only in its high state.
// - Fixed oscillator clocks a timer giving periodic operating system ticks.
`default_nettype none
module brd_reset_dist #(
	parameter int unsigned WDT_CYC = int'(brd_pkg::WDT_CYC),
	parameter int unsigned TICK_EDGES = int'(brd_pkg::TICK_EDGES)
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic power_on_reset_raw_n,
	input wire logic switch_rst_n,
	input wire logic jtag_srst_n,
	input wire logic central_mode,
	input wire logic blank_prog_mode,
	input wire logic flash_prog_hold,
	input wire logic wdt_enable,
	input wire logic wdt_kick,
	input wire logic sw_pci_rst,
	input wire logic pci_release_set,
	input wire logic core_sys_rst,
	input wire logic mclk_stall,
	input wire logic timer_osc,
	input wire logic pci_rst_i_n,
	output logic cpu_mst_rst_n,
	output logic core_rst_n,
	output logic flash_rst_n,
	output logic xbus_rst,
	output logic pci_rst_o_n,
	output logic pci_rst_oe_n,
	output logic mclk,
	output logic os_tick,
	output logic wdt_fired
);
	// ==========================================================
	// State
	typedef struct packed {
		brd_pkg::brd_seq_type st;
		logic [brd_pkg::HOLD_W-1:0] hold_cnt;
		logic [brd_pkg::WDT_W-1:0] wdt_cnt;
		logic [brd_pkg::TICK_W-1:0] tick_cnt;
		logic osc_q;
		logic caught;
		logic blank;
		logic cpu_n;
		logic core_n;
		logic flash_n;
		logic pci_o_n;
		logic pci_oe_n;
		logic mclk;
		logic tick;
		logic fired;
	} brd_top_state_type;

	brd_top_state_type q_r;
	brd_top_state_type q_nxt;
	brd_dbnc_if db ();
	logic wdt_exp;
	logic hold_cpu;
	logic host_local_n;

	// One debouncer for all three sources keeps their paths identical
	assign db.raw_n = power_on_reset_raw_n & switch_rst_n & jtag_srst_n;

	brd_debounce #(
		.DB_CYC(brd_pkg::DB_CYC)
	) u_debounce (
		.clk(clk),
		.reset(reset),
		.f(db)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		q_nxt = q_r;
		q_nxt.tick = 1'h0;
		wdt_exp = 1'h0;

		// Strap caught once after release; only a power cycle clears it
		if (!q_r.caught)
		begin
			q_nxt.caught = 1'h1;
			q_nxt.blank = blank_prog_mode;
		end

		// Watchdog counts only while enabled and the system runs
		if (!wdt_enable || wdt_kick || q_r.st != brd_pkg::ST_RUN)
			q_nxt.wdt_cnt = '0;
		else if (q_r.wdt_cnt == brd_pkg::WDT_W'(WDT_CYC - 1))
		begin
			wdt_exp = 1'h1;
			q_nxt.wdt_cnt = '0;
		end
		else
			q_nxt.wdt_cnt = q_r.wdt_cnt + brd_pkg::WDT_W'(1);
		q_nxt.fired = wdt_exp;

		// Reset sequencer
		case (q_r.st)
			brd_pkg::ST_POR:
				if (pci_release_set)
					q_nxt.st = brd_pkg::ST_RUN;
			brd_pkg::ST_RUN:
				if (wdt_exp || core_sys_rst)
				begin
					q_nxt.st = brd_pkg::ST_HOLD;
					q_nxt.hold_cnt = '0;
				end
			brd_pkg::ST_HOLD:
				if (q_r.hold_cnt == brd_pkg::HOLD_W'(brd_pkg::HOLD_CYC - 1))
					q_nxt.st = brd_pkg::ST_POR;
				else
					q_nxt.hold_cnt = q_r.hold_cnt + brd_pkg::HOLD_W'(1);
			default:
				q_nxt.st = brd_pkg::ST_POR;
		endcase
		// A fresh debounced reset in host mode, or PCI reset in add-in mode, restarts from the power-up hold
		if ((central_mode && !db.clean_n) || (!central_mode && !pci_rst_i_n))
			q_nxt.st = brd_pkg::ST_POR;

		// Reset distribution
		hold_cpu = flash_prog_hold || q_r.blank || !q_r.caught;
		host_local_n = db.clean_n && q_r.st != brd_pkg::ST_HOLD;
		if (central_mode)
		begin
			q_nxt.flash_n = host_local_n;
			q_nxt.core_n = host_local_n;
			q_nxt.cpu_n = host_local_n && !hold_cpu;
			q_nxt.pci_o_n = host_local_n && q_r.st != brd_pkg::ST_POR
				&& !sw_pci_rst;
			q_nxt.pci_oe_n = 1'h0;
		end
		else
		begin
			q_nxt.flash_n = pci_rst_i_n;
			q_nxt.core_n = pci_rst_i_n;
			q_nxt.cpu_n = pci_rst_i_n && q_r.st != brd_pkg::ST_HOLD
				&& !hold_cpu;
			q_nxt.pci_o_n = 1'h1;
			q_nxt.pci_oe_n = 1'h1; // Pin is an input in this mode
		end

		// Memory clock halves the system clock; a stall parks it high
		q_nxt.mclk = (mclk_stall && q_r.mclk) ? 1'h1 : !q_r.mclk;

		// Count rising edges of the fixed oscillator into ticks
		q_nxt.osc_q = timer_osc;
		if (timer_osc && !q_r.osc_q)
		begin
			if (q_r.tick_cnt == brd_pkg::TICK_W'(TICK_EDGES - 1))
			begin
				q_nxt.tick_cnt = '0;
				q_nxt.tick = 1'h1;
			end
			else
				q_nxt.tick_cnt = q_r.tick_cnt + brd_pkg::TICK_W'(1);
		end
	end

	// ==========================================================
	// Registers, everything held in reset while reset is high
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			q_r <= '0;
			q_r.st <= brd_pkg::ST_POR;
			q_r.pci_oe_n <= 1'h1;
			q_r.mclk <= brd_pkg::MCLK_RST;
		end
		else
			q_r <= q_nxt;
	end

	// Outputs straight from flops, xbus_rst through an inverter
	assign cpu_mst_rst_n = q_r.cpu_n;
	assign core_rst_n = q_r.core_n;
	assign flash_rst_n = q_r.flash_n;
	assign xbus_rst = !q_r.flash_n;
	assign pci_rst_o_n = q_r.pci_o_n;
	assign pci_rst_oe_n = q_r.pci_oe_n;
	assign mclk = q_r.mclk;
	assign os_tick = q_r.tick;
	assign wdt_fired = q_r.fired;

	// ==========================================================
	// Checks
	property p_host_local;
		@(posedge clk) disable iff (reset)
		central_mode && !db.clean_n |=> !flash_rst_n && !cpu_mst_rst_n
			&& !core_rst_n && !pci_rst_o_n && !pci_rst_oe_n;
	endproperty
	a_host_local: assert property (p_host_local)
		else $error("host mode local reset not distributed");

	property p_core_req;
		@(posedge clk) disable iff (reset)
		central_mode && core_sys_rst && q_r.st == brd_pkg::ST_RUN
			&& db.clean_n |=> q_r.st == brd_pkg::ST_HOLD ##1 !pci_rst_o_n;
	endproperty
	a_core_req: assert property (p_core_req)
		else $error("core reset request did not reach the pci reset");

	property p_xbus_inv;
		@(posedge clk) disable iff (reset)
		central_mode && q_r.st == brd_pkg::ST_HOLD |=> xbus_rst && !flash_rst_n;
	endproperty
	a_xbus_inv: assert property (p_xbus_inv)
		else $error("expansion reset missing during local reset hold");

	property p_wdt_enable;
		@(posedge clk) disable iff (reset)
		!wdt_enable |=> !wdt_fired;
	endproperty
	a_wdt_enable: assert property (p_wdt_enable)
		else $error("watchdog fired while disabled");

	property p_wdt_master;
		@(posedge clk) disable iff (reset)
		wdt_fired |=> (!cpu_mst_rst_n && (!central_mode || !flash_rst_n))[*2];
	endproperty
	a_wdt_master: assert property (p_wdt_master)
		else $error("watchdog did not assert master reset");

	property p_pci_hold;
		@(posedge clk) disable iff (reset)
		central_mode && q_r.st == brd_pkg::ST_POR && !pci_release_set
			|=> !pci_rst_o_n;
	endproperty
	a_pci_hold: assert property (p_pci_hold)
		else $error("pci reset released without the control bit");

	property p_addin;
		@(posedge clk) disable iff (reset)
		!central_mode && !pci_rst_i_n |=> !cpu_mst_rst_n && !core_rst_n
			&& !flash_rst_n && xbus_rst && pci_rst_oe_n;
	endproperty
	a_addin: assert property (p_addin)
		else $error("add-in reset not followed");

	property p_prog_hold;
		@(posedge clk) disable iff (reset)
		flash_prog_hold |=> !cpu_mst_rst_n;
	endproperty
	a_prog_hold: assert property (p_prog_hold)
		else $error("processor left reset during programming hold");

	property p_blank;
		@(posedge clk) disable iff (reset)
		q_r.caught && q_r.blank |=> (q_r.blank && !cpu_mst_rst_n)[*3];
	endproperty
	a_blank: assert property (p_blank)
		else $error("blank programming mode released the processor");

	property p_mclk_high;
		@(posedge clk) disable iff (reset)
		mclk_stall && mclk |=> mclk;
	endproperty
	a_mclk_high: assert property (p_mclk_high)
		else $error("memory clock stalled low");

	property p_tick;
		@(posedge clk) disable iff (reset)
		os_tick |=> !os_tick ##0 q_r.tick_cnt == '0;
	endproperty
	a_tick: assert property (p_tick)
		else $error("timer tick malformed");

	c_wdt: cover property (@(posedge clk) disable iff (reset) wdt_fired);
	c_release: cover property (@(posedge clk) disable iff (reset)
		central_mode && $rose(pci_rst_o_n));
	c_addin: cover property (@(posedge clk) disable iff (reset)
		!central_mode && $rose(cpu_mst_rst_n));
	c_stall: cover property (@(posedge clk) disable iff (reset)
		mclk_stall && mclk ##1 mclk ##1 mclk);
endmodule : brd_reset_dist
`default_nettype wire

// File: verif/brd_pci_host_model.sv
`default_nettype none
module brd_pci_host_model (
	input wire logic hold_rst,
	input wire logic pci_rst_o_n,
	input wire logic pci_rst_oe_n,
	output logic pci_wire_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Shared reset wire
	// Card drives when enabled, else the host; pull-up keeps it high idle
	assign pci_wire_n = !pci_rst_oe_n ? pci_rst_o_n : !hold_rst;
endmodule : brd_pci_host_model
`default_nettype wire

// File: verif/tb_board_reset_distribution.sv
`default_nettype none
module tb_board_reset_distribution;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned WDT = 50;
	localparam int unsigned TK = 4;
	localparam int DB = brd_pkg::DB_CYC;
	// ==========================================================
	// Stimulus and observed signals
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic por_n = 1'h1, sw_n = 1'h1, jt_n = 1'h1, cen = 1'h1, blank = 1'h0;
	logic hold = 1'h0, wen = 1'h0, kick = 1'h0, swp = 1'h0, rel = 1'h0;
	logic csr = 1'h0, stall = 1'h0, osc = 1'h0, host_rst = 1'h0;
	logic cpu, core, fl, xb, po, poe, mclk, tick, fired, pin;
	int err_count = 0;
	int n_tests = 0;

	// Slow clock keeps long counts cheap only through small parameters
	always #50 clk = ~clk;

	brd_reset_dist #(.WDT_CYC(WDT), .TICK_EDGES(TK)) u_brd_reset_dist (
		.clk(clk), .reset(reset), .power_on_reset_raw_n(por_n),
		.switch_rst_n(sw_n), .jtag_srst_n(jt_n), .central_mode(cen),
		.blank_prog_mode(blank), .flash_prog_hold(hold), .wdt_enable(wen),
		.wdt_kick(kick), .sw_pci_rst(swp), .pci_release_set(rel),
		.core_sys_rst(csr), .mclk_stall(stall), .timer_osc(osc),
		.pci_rst_i_n(pin), .cpu_mst_rst_n(cpu), .core_rst_n(core),
		.flash_rst_n(fl), .xbus_rst(xb), .pci_rst_o_n(po),
		.pci_rst_oe_n(poe), .mclk(mclk), .os_tick(tick), .wdt_fired(fired)
	);

	brd_pci_host_model u_brd_pci_host_model (
		.hold_rst(host_rst), .pci_rst_o_n(po), .pci_rst_oe_n(poe),
		.pci_wire_n(pin)
	);

	// ==========================================================
	// Helpers
	function automatic logic [5:0] st();
		return {cpu, core, fl, xb, po, poe};
	endfunction : st

	task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Sample just after the edge so the design's updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic do_reset(input logic c, input logic b);
		@(posedge clk);
		reset <= 1'h1;
		cen <= c;
		blank <= b;
		repeat (12) @(posedge clk);
		#1;
		chk(st(), 6'h05);
		@(posedge clk);
		reset <= 1'h0;
	endtask : do_reset

	task automatic release_pci;
		@(posedge clk);
		rel <= 1'h1;
		@(posedge clk);
		rel <= 1'h0;
		cyc(2);
	endtask : release_pci

	task automatic put(input int i, input logic v);
		@(posedge clk);
		case (i)
			0: por_n <= v;
			1: sw_n <= v;
			default: jt_n <= v;
		endcase
	endtask : put

	task automatic final_report;
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	// ==========================================================
	// Scenarios
	task automatic sc_por;
		cyc(DB + 3);
		chk(st(), 6'h38);
		release_pci();
		chk(st(), 6'h3a);
	endtask : sc_por

	// Every source: a short glitch is ignored, a long press resets all
	task automatic sc_src;
		for (int i = 0; i < 3; i++)
		begin
			put(i, 1'h0);
			repeat (50) @(posedge clk);
			put(i, 1'h1);
			cyc(60);
			chk(st(), 6'h3a);
			put(i, 1'h0);
			cyc(DB + 20);
			chk(st(), 6'h04);
			put(i, 1'h1);
			cyc(DB + 3);
			chk(st() & 6'h3d, 6'h38);
			release_pci();
			chk(st(), 6'h3a);
		end
	endtask : sc_src

	task automatic sc_levels;
		@(posedge clk);
		swp <= 1'h1;
		cyc(3);
		chk(st(), 6'h38);
		@(posedge clk);
		swp <= 1'h0;
		hold <= 1'h1;
		cyc(3);
		chk(st(), 6'h1a);
		@(posedge clk);
		hold <= 1'h0;
		cyc(3);
		chk(st(), 6'h3a);
	endtask : sc_levels

	task automatic sc_mclk;
		@(posedge clk);
		stall <= 1'h1;
		cyc(3);
		repeat (6)
		begin
			cyc(1);
			chk({5'h00, mclk}, 6'h01);
		end
		@(posedge clk);
		stall <= 1'h0;
		cyc(1);
		chk({5'h00, mclk}, 6'h00);
		cyc(1);
		chk({5'h00, mclk}, 6'h01);
	endtask : sc_mclk

	task automatic sc_tick;
		int n;
		n = 0;
		repeat (3 * TK)
		begin
			@(posedge clk);
			osc <= 1'h1;
			cyc(1);
			n += int'(tick);
			@(posedge clk);
			osc <= 1'h0;
			cyc(1);
			n += int'(tick);
		end
		repeat (4)
		begin
			cyc(1);
			n += int'(tick);
		end
		chk(6'(n), 6'h03);
	endtask : sc_tick

	// Kicked or disabled timer stays quiet; neglected one resets all
	task automatic sc_wdt;
		logic nf;
		int i;
		nf = 1'h0;
		@(posedge clk);
		wen <= 1'h1;
		kick <= 1'h1;
		repeat (3 * WDT)
		begin
			cyc(1);
			nf |= fired;
		end
		@(posedge clk);
		wen <= 1'h0;
		kick <= 1'h0;
		repeat (3 * WDT)
		begin
			cyc(1);
			nf |= fired;
		end
		chk({5'h00, nf}, 6'h00);
		@(posedge clk);
		wen <= 1'h1;
		for (i = 0; i < WDT + 20 && fired !== 1'h1; i++)
			cyc(1);
		chk({5'h00, fired}, 6'h01);
		@(posedge clk);
		wen <= 1'h0;
		#1;
		chk(st(), 6'h04);
		cyc(190);
		chk(st(), 6'h04);
		cyc(25);
		chk(st(), 6'h38);
		release_pci();
	endtask : sc_wdt

	task automatic sc_core;
		@(posedge clk);
		csr <= 1'h1;
		@(posedge clk);
		csr <= 1'h0;
		cyc(2);
		chk(st(), 6'h04);
		cyc(215);
		release_pci();
		chk(st(), 6'h3a);
	endtask : sc_core

	task automatic sc_addin;
		do_reset(1'h0, 1'h0);
		cyc(DB + 3);
		chk(st() & 6'h3d, 6'h39);
		@(posedge clk);
		host_rst <= 1'h1;
		cyc(1);
		chk(st() & 6'h3d, 6'h05);
		@(posedge clk);
		host_rst <= 1'h0;
		cyc(3);
		chk(st() & 6'h3d, 6'h39);
	endtask : sc_addin

	task automatic sc_blank;
		do_reset(1'h1, 1'h1);
		cyc(DB + 3);
		chk(st(), 6'h18);
		cyc(50);
		chk(st(), 6'h18);
	endtask : sc_blank

	// ==========================================================
	// Main sequence and hang guard
	initial
	begin
		do_reset(1'h1, 1'h0);
		sc_por();
		sc_src();
		sc_levels();
		sc_mclk();
		sc_tick();
		sc_wdt();
		sc_core();
		sc_addin();
		sc_blank();
		final_report();
	end

	// Run needs about 2300 cycles; allow a wide margin
	initial
	begin
		#(20000 * 100);
		err_count++;
		final_report();
	end
endmodule : tb_board_reset_distribution
`default_nettype wire
